// ===== verilog/fpx_pkg.sv
// shared constants, types and structs for the floating exception unit
package fpx_pkg;

  // trap vector, 244 octal
  localparam logic [8:0] TRAP_VECTOR = 9'h0A4;

  // reset values of the exception registers
  localparam logic [3:0] EXC_CODE_RESET = 4'h0;
  localparam logic [15:0] EXC_ADDR_RESET = 16'h0000;

  // autoincrement and autodecrement step in bytes
  localparam logic [3:0] STEP_SINGLE = 4'h4;
  localparam logic [3:0] STEP_DOUBLE = 4'h8;

  // highest accumulator per addressing class
  localparam logic [2:0] AC_MAX_REG_MODE = 3'h5;
  localparam logic [2:0] AC_MAX_MEM_MODE = 3'h3;

  // field widths
  localparam int EXP_W = 8;
  localparam int FRAC_S = 24;
  localparam int FRAC_D = 56;
  localparam int GUARD_W = 2;
  localparam int RAW_W = FRAC_D + GUARD_W;

  // rounding increments, lsb at bit 0 of the fraction for double, bit 32 for single precision
  localparam logic [56:0] RND_INC_DOUBLE = 57'h000_0000_0000_0001;
  localparam logic [56:0] RND_INC_SINGLE = 57'h000_0001_0000_0000;

  // exponent limits, signed biased values
  localparam logic signed [9:0] EXP_MAX = 10'sh0FF;
  localparam logic signed [9:0] EXP_MIN = 10'sh001;
  localparam logic [7:0] EXP_ZERO = 8'h00;

  // largest biased exponent that still converts to 16 or 32 bit integer
  localparam logic [7:0] CONV_LIMIT_SHORT = 8'h8F;
  localparam logic [7:0] CONV_LIMIT_LONG = 8'h9F;

  typedef enum logic [3:0] {
    CODE_NONE = 4'b0000,
    CODE_OPCODE = 4'b0010,
    CODE_DIV0 = 4'b0100,
    CODE_CONV = 4'b0110,
    CODE_OVF = 4'b1000,
    CODE_UNF = 4'b1010,
    CODE_UNDEF = 4'b1100,
    CODE_MAINT = 4'b1110
  } fpx_code_t;

  typedef enum logic [2:0] {
    MODE_AC = 3'b000,
    MODE_DEFER = 3'b001,
    MODE_AINC = 3'b010,
    MODE_AINC_DEF = 3'b011,
    MODE_ADEC = 3'b100,
    MODE_ADEC_DEF = 3'b101,
    MODE_INDEX = 3'b110,
    MODE_INDEX_DEF = 3'b111
  } fpx_mode_t;

  typedef enum logic [2:0] {
    OP_OTHER = 3'b000,
    OP_ADD = 3'b001,
    OP_SUB = 3'b010,
    OP_MUL = 3'b011,
    OP_DIV = 3'b100,
    OP_LOAD = 3'b101,
    OP_CONV = 3'b110,
    OP_ILLEGAL = 3'b111
  } fpx_op_t;

  typedef struct packed {
    logic global_trap_inhibit;
    logic undefined_value_trap_enable;
    logic underflow_trap_enable;
    logic overflow_trap_enable;
    logic conversion_trap_enable;
    logic maint_trap_enable;
    logic precision_select;
    logic long_integer_select;
    logic chop_select;
  } fpx_ctrl_t;

  typedef struct packed {
    logic [15:0] addr;
    fpx_op_t kind;
    fpx_mode_t mode;
    logic [2:0] gen_reg;
    logic [2:0] float_accumulator;
    logic src_sign;
    logic [7:0] src_exp;
    logic maint_event;
  } fpx_instr_t;

  typedef struct packed {
    logic sign;
    logic signed [9:0] exp;
    logic [57:0] frac;
    logic zero;
  } fpx_raw_t;

  typedef struct packed {
    logic sign;
    logic [7:0] exp;
    logic [55:0] frac;
  } fpx_result_t;

endpackage

// ===== verilog/fpx_round_unit.sv
// chop or round of a normalised fraction with two guard bits
`timescale 1ns/100ps
module fpx_round_unit
(
  input wire logic [57:0] frac_in,
  input wire logic signed [9:0] exp_in,
  input wire logic precision_select,
  input wire logic chop_select,
  output logic [55:0] frac_out,
  output logic signed [9:0] exp_out
);
  import fpx_pkg::*;

  logic [55:0] chopped;
  logic round_bit;
  logic [56:0] inc;
  logic [56:0] sum;

  // keep 24 or 56 fraction bits, guard bits below
  assign chopped = precision_select ? frac_in[57:2] :
                   {frac_in[57:34], 32'h0000_0000};
  // first discarded bit is the rounding bit
  assign round_bit = precision_select ? frac_in[1] : frac_in[33];
  assign inc = precision_select ? RND_INC_DOUBLE : RND_INC_SINGLE;
  assign sum = {1'b0, chopped} +
               ((round_bit && !chop_select) ? inc : 57'h0);
  // carry out of rounding renormalises
  assign frac_out = sum[56] ? sum[56:1] : sum[55:0];
  assign exp_out = sum[56] ? exp_in + 10'sd1 : exp_in;

endmodule // fpx_round_unit

// ===== verilog/fpx_exception_unit.sv
// floating exception code/address registers and operand handling
//
// Operation
// - all floating exceptions use vector 244
// - four-bit code: 2,4,6,8,10,12,14 as listed
// - address register takes faulting instruction address
// - update on divide zero, opcode, enabled others
// - disabled exception leaves both registers unchanged
// - global inhibit stops interrupt, not register update
// - clean instruction leaves both registers unchanged
// - no instruction writes them; read via store-status
// - eight modes; mode 0 selects accumulator
// - autostep 4 single, 8 double bytes
// - mode 0 allows accumulators 0-5, else opcode trap
// - other modes allow accumulators 0-3 only
// - most significant word at lowest address
// - zero exponent is zero; minus zero may trap
// - zero divisor traps; zero dividend exact
// - fractions 24 bits single, 56 bits double
// - at least two guard bits kept
// - rounding adds rounding bit at one lsb
// - flag overflow/underflow outside eight-bit exponent
// - disabled underflow gives zero, no interrupt
// - enabled overflow/underflow stores low exponent bits
// - precision and long integer mode selection
// - sticky error set on exception, cleared by load-status
`timescale 1ns/100ps
module fpx_exception_unit
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire fpx_pkg::fpx_ctrl_t ctrl,
  input wire logic instr_valid,
  input wire fpx_pkg::fpx_instr_t instr,
  input wire fpx_pkg::fpx_raw_t raw,
  input wire logic load_status_op,
  input wire logic store_status_op,
  input wire logic [1:0] mem_word_idx,
  output logic instr_done,
  output logic result_valid,
  output fpx_pkg::fpx_result_t result,
  output logic [15:0] mem_word,
  output logic [3:0] exception_code,
  output logic [15:0] exception_address,
  output logic sticky_error_flag,
  output logic trap_request,
  output logic [8:0] trap_vector,
  output logic status_read_valid,
  output logic [3:0] addr_step,
  output logic operand_in_ac
);
  import fpx_pkg::*;

  logic [55:0] rnd_frac;
  logic signed [9:0] rnd_exp;
  logic ac_illegal;
  logic opc_err;
  logic src_in_mem;
  logic reads_src;
  logic is_arith;
  logic undef_hit;
  logic div0;
  logic conv_fail;
  logic ovf;
  logic unf;
  logic [7:0] conv_limit;
  logic exc_take;
  fpx_code_t exc_code;
  logic writes_result;
  logic force_zero;
  fpx_result_t next_result;
  logic [63:0] packed_word;
  logic next_sticky;
  logic record;

  fpx_round_unit u_round (
    .frac_in(raw.frac),
    .exp_in(raw.exp),
    .precision_select(ctrl.precision_select),
    .chop_select(ctrl.chop_select),
    .frac_out(rnd_frac),
    .exp_out(rnd_exp)
  );

  // accumulator range depends on addressing class
  assign ac_illegal = (instr.mode == MODE_AC) ?
                      (instr.float_accumulator > AC_MAX_REG_MODE) :
                      (instr.float_accumulator > AC_MAX_MEM_MODE);
  assign opc_err = (instr.kind == OP_ILLEGAL) || ac_illegal;
  // mode 0 operand lives in an accumulator
  assign src_in_mem = (instr.mode != MODE_AC);
  assign reads_src = (instr.kind == OP_ADD) || (instr.kind == OP_SUB) ||
                     (instr.kind == OP_MUL) || (instr.kind == OP_DIV) ||
                     (instr.kind == OP_LOAD);
  assign is_arith = (instr.kind == OP_ADD) || (instr.kind == OP_SUB) ||
                    (instr.kind == OP_MUL) || (instr.kind == OP_DIV);

  // minus zero from memory traps only when enabled
  assign undef_hit = reads_src && src_in_mem && instr.src_sign &&
                     (instr.src_exp == EXP_ZERO) &&
                     ctrl.undefined_value_trap_enable;
  // zero divisor, dividend zero handled as exact by raw.zero
  assign div0 = (instr.kind == OP_DIV) &&
                (instr.src_exp == EXP_ZERO);
  // integer width limit from long integer mode
  assign conv_limit = ctrl.long_integer_select ?
                      CONV_LIMIT_LONG : CONV_LIMIT_SHORT;
  assign conv_fail = (instr.kind == OP_CONV) &&
                     (instr.src_exp > conv_limit);
  // exponent does not fit in eight bits
  assign ovf = is_arith && !raw.zero && (rnd_exp > EXP_MAX);
  assign unf = is_arith && !raw.zero && (rnd_exp < EXP_MIN);

  // priority of exception sources and whether they record
  always_comb
  begin
    exc_code = CODE_NONE;
    exc_take = 1'b0;
    if (opc_err)
    begin
      exc_code = CODE_OPCODE;
      exc_take = 1'b1;
    end
    else if (undef_hit)
    begin
      exc_code = CODE_UNDEF;
      exc_take = 1'b1;
    end
    else if (div0)
    begin
      exc_code = CODE_DIV0;
      exc_take = 1'b1;
    end
    else if (conv_fail)
    begin
      exc_code = CODE_CONV;
      exc_take = ctrl.conversion_trap_enable;
    end
    else if (ovf)
    begin
      exc_code = CODE_OVF;
      exc_take = ctrl.overflow_trap_enable;
    end
    else if (unf)
    begin
      exc_code = CODE_UNF;
      exc_take = ctrl.underflow_trap_enable;
    end
    else if (instr.maint_event)
    begin
      exc_code = CODE_MAINT;
      exc_take = ctrl.maint_trap_enable;
    end
    else
    begin
      exc_code = CODE_NONE;
      exc_take = 1'b0;
    end
  end

  assign record = instr_valid && exc_take;

  // result path: aborted ops write nothing
  assign writes_result = instr_valid && reads_src &&
                         !opc_err && !undef_hit && !div0;
  assign force_zero = raw.zero || (ovf && !ctrl.overflow_trap_enable) ||
                      (unf && !ctrl.underflow_trap_enable);
  // enabled overflow/underflow keep low eight exponent bits
  assign next_result = force_zero ? '0 :
                       {raw.sign, rnd_exp[7:0], rnd_frac};

  // memory image, hidden bit dropped
  assign packed_word = {result.sign, result.exp, result.frac[54:0]};

  // set wins over load-status clear
  assign next_sticky = record ||
                       (sticky_error_flag && !load_status_op);

  // exception registers, no write path from software
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      exception_code <= EXC_CODE_RESET;
      exception_address <= EXC_ADDR_RESET;
    end
    else if (record)
    begin
      exception_code <= exc_code;
      exception_address <= instr.addr;
    end
  end

  // interrupt request and status flags
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      trap_request <= 1'b0;
      trap_vector <= TRAP_VECTOR;
      sticky_error_flag <= 1'b0;
      status_read_valid <= 1'b0;
      instr_done <= 1'b0;
    end
    else
    begin
      trap_request <= record && !ctrl.global_trap_inhibit;
      trap_vector <= TRAP_VECTOR;
      sticky_error_flag <= next_sticky;
      status_read_valid <= store_status_op;
      instr_done <= instr_valid;
    end
  end

  // result register
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      result <= '0;
      result_valid <= 1'b0;
    end
    else
    begin
      result_valid <= writes_result;
      if (writes_result)
      begin
        result <= next_result;
      end
    end
  end

  // addressing support and word order
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      addr_step <= STEP_SINGLE;
      operand_in_ac <= 1'b0;
      mem_word <= 16'h0000;
    end
    else
    begin
      addr_step <= ctrl.precision_select ? STEP_DOUBLE : STEP_SINGLE;
      if (instr_valid)
      begin
        operand_in_ac <= !src_in_mem;
      end
      mem_word <= packed_word[6'd63 - {mem_word_idx, 4'h0} -: 16];
    end
  end

  // checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  sequence seq_recorded;
    instr_valid && exc_take;
  endsequence

  sequence seq_quiet;
    instr_valid && !exc_take;
  endsequence

  AST_VECTOR: assert property (
    trap_request |-> trap_vector == TRAP_VECTOR)
    else $error("trap raised with wrong vector");

  AST_CODE_EVEN: assert property (
    seq_recorded |=> exception_code[0] == 1'b0 &&
                     exception_code != CODE_NONE)
    else $error("exception code not a valid even code");

  AST_ADDR: assert property (
    seq_recorded |=> exception_address == $past(instr.addr))
    else $error("exception address not loaded");

  AST_DIV0: assert property (
    instr_valid && div0 && !opc_err && !undef_hit
    |=> exception_code == CODE_DIV0 && !result_valid)
    else $error("divide by zero not recorded");

  AST_HOLD: assert property (
    seq_quiet |=> $stable(exception_code) && $stable(exception_address))
    else $error("exception registers changed without exception");

  AST_INHIBIT: assert property (
    seq_recorded ##0 ctrl.global_trap_inhibit
    |=> !trap_request && exception_address == $past(instr.addr))
    else $error("inhibit blocked register update or raised trap");

  AST_NO_EXC: assert property (
    instr_valid && exc_code == CODE_NONE |=> $stable(exception_code))
    else $error("clean instruction changed exception code");

  AST_STEP: assert property (
    ctrl.precision_select ##1 ctrl.precision_select
    |-> addr_step == STEP_DOUBLE)
    else $error("double precision step not eight");

  AST_AC_REG: assert property (
    instr_valid && instr.mode == MODE_AC &&
    instr.float_accumulator > AC_MAX_REG_MODE
    |=> exception_code == CODE_OPCODE &&
        trap_request == !$past(ctrl.global_trap_inhibit))
    else $error("accumulator 6 or 7 did not trap");

  AST_AC_MEM: assert property (
    instr_valid && instr.mode != MODE_AC &&
    instr.float_accumulator > AC_MAX_MEM_MODE
    |=> exception_code == CODE_OPCODE)
    else $error("accumulator above 3 accepted in memory mode");

  AST_WORD0: assert property (
    mem_word_idx == 2'b00
    |=> mem_word == $past({result.sign, result.exp, result.frac[54:48]}))
    else $error("lowest word is not most significant");

  AST_UNF_ZERO: assert property (
    writes_result && unf && !ovf && !ctrl.underflow_trap_enable
    |=> result == '0 && !trap_request)
    else $error("disabled underflow not replaced by zero");

  AST_OVF_EXP: assert property (
    writes_result && ovf && ctrl.overflow_trap_enable
    |=> result.exp == $past(rnd_exp[7:0]) && exception_code == CODE_OVF)
    else $error("enabled overflow stored wrong exponent");

  AST_STICKY: assert property (
    sticky_error_flag && !load_status_op |=> sticky_error_flag)
    else $error("sticky error flag cleared by itself");

  AST_STICKY_SET: assert property (
    seq_recorded |=> sticky_error_flag [*1])
    else $error("sticky error flag not set on exception");

  AST_MODE0: assert property (
    instr_valid |=> operand_in_ac == ($past(instr.mode) == MODE_AC))
    else $error("operand location flag does not follow mode");

endmodule // fpx_exception_unit

// ===== bench/fpx_host_model.sv
// host processor model issuing floating instructions
`timescale 1ns/100ps
module fpx_host_model
(
  input wire logic sys_clk,
  output logic instr_valid,
  output fpx_pkg::fpx_instr_t instr,
  output fpx_pkg::fpx_raw_t raw,
  output logic load_status_op,
  output logic store_status_op
);
  import fpx_pkg::*;

  initial
  begin
    instr_valid = 1'b0;
    instr = '0;
    raw = '0;
    load_status_op = 1'b0;
    store_status_op = 1'b0;
  end

  // one instruction for a single cycle, then scrambled fields
  task automatic issue(input fpx_op_t k, input fpx_mode_t m,
    input logic [2:0] ac, input logic [8:0] src, input logic [9:0] re,
    input logic [57:0] rf, input logic mt, input logic [15:0] a);
    @(negedge sys_clk);
    instr_valid = 1'b1;
    instr = '{addr: a, kind: k, mode: m, gen_reg: 3'h1,
      float_accumulator: ac, src_sign: src[8], src_exp: src[7:0],
      maint_event: mt};
    raw = '{sign: 1'b0, exp: re, frac: rf, zero: (rf == 58'h0)};
    @(negedge sys_clk);
    instr_valid = 1'b0;
    instr = ~instr;
    raw = ~raw;
  endtask

  // store-status or load-status pulse
  task automatic status(input logic ld);
    @(negedge sys_clk);
    load_status_op = ld;
    store_status_op = ~ld;
    @(negedge sys_clk);
    load_status_op = 1'b0;
    store_status_op = 1'b0;
  endtask
endmodule // fpx_host_model

// ===== bench/tb_top.sv
// self-checking bench for the floating exception unit
`timescale 1ns/100ps
module tb_top;
  import fpx_pkg::*;
  localparam logic [8:0] S = 9'h080;
  localparam logic [9:0] E = 10'h080;
  localparam logic [57:0] F = 58'h200000000000000;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  fpx_ctrl_t ctrl = '0;
  logic [1:0] mem_word_idx = 2'h0;
  logic instr_valid, load_status_op, store_status_op;
  fpx_instr_t instr;
  fpx_raw_t raw;
  logic instr_done, result_valid, sticky_error_flag, trap_request;
  logic status_read_valid, operand_in_ac;
  fpx_result_t result;
  logic [15:0] mem_word, exception_address, adr, xa;
  logic [3:0] exception_code, addr_step, xc;
  logic [8:0] trap_vector;
  int n_fail = 0;
  int n_tests = 0;
  int cycles = 0;

  always #10 sys_clk = ~sys_clk;

  fpx_host_model fpx_host_model_inst (.sys_clk, .instr_valid, .instr,
    .raw, .load_status_op, .store_status_op);

  fpx_exception_unit fpx_exception_unit_inst (.sys_clk, .resetn, .ctrl,
    .instr_valid, .instr, .raw, .load_status_op, .store_status_op,
    .mem_word_idx, .instr_done, .result_valid, .result, .mem_word,
    .exception_code, .exception_address, .sticky_error_flag,
    .trap_request, .trap_vector, .status_read_valid, .addr_step,
    .operand_in_ac);

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t seen %0h expected %0h",
        $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // issue one instruction and compare the exception state
  task automatic t(input fpx_op_t k, input fpx_mode_t m,
    input logic [2:0] ac, input logic [8:0] src, input logic [9:0] re,
    input logic [57:0] rf, input logic mt, input logic [3:0] c,
    input logic tr, input int rv);
    adr = adr + 16'h0004;
    fpx_host_model_inst.issue(k, m, ac, src, re, rf, mt, adr);
    if (c != 4'h0)
    begin
      xc = c;
      xa = adr;
    end
    chk(exception_code, xc);
    chk(exception_address, xa);
    chk(trap_request, tr);
    chk(instr_done, 1'b1);
    if (rv < 2)
      chk(result_valid, rv[0]);
    if (c != 4'h0)
      chk(sticky_error_flag, 1'b1);
  endtask

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      n_fail++;
      report_and_stop;
    end
  end

  initial
  begin
    adr = 16'h1000;
    xa = 16'h0000;
    xc = 4'h0;
    repeat (2) @(negedge sys_clk);
    resetn = 1'b1;
    chk(trap_vector, 9'h0A4);
    chk(addr_step, 4'h4);
    chk(exception_code, 4'h0);
    t(OP_ADD, MODE_AC, 3'h0, S, E, F, 1'b0, 4'h0, 1'b0, 1);
    chk(operand_in_ac, 1'b1);
    t(OP_ILLEGAL, MODE_AC, 3'h0, S, E, F, 1'b0, 4'h2, 1'b1, 0);
    t(OP_ADD, MODE_AC, 3'h5, S, E, F, 1'b0, 4'h0, 1'b0, 1);
    t(OP_ADD, MODE_AC, 3'h6, S, E, F, 1'b0, 4'h2, 1'b1, 0);
    t(OP_ADD, MODE_AC, 3'h7, S, E, F, 1'b0, 4'h2, 1'b1, 0);
    t(OP_ADD, MODE_AINC, 3'h4, S, E, F, 1'b0, 4'h2, 1'b1, 0);
    chk(operand_in_ac, 1'b0);
    t(OP_SUB, MODE_ADEC, 3'h3, S, E, F, 1'b0, 4'h0, 1'b0, 1);
    t(OP_DIV, MODE_DEFER, 3'h0, 9'h000, E, F, 1'b0, 4'h4, 1'b1, 0);
    t(OP_MUL, MODE_DEFER, 3'h0, 9'h100, E, F, 1'b0, 4'h0, 1'b0, 1);
    ctrl.undefined_value_trap_enable = 1'b1;
    t(OP_MUL, MODE_DEFER, 3'h0, 9'h100, E, F, 1'b0, 4'hC, 1'b1, 0);
    t(OP_MUL, MODE_AC, 3'h0, 9'h100, E, F, 1'b0, 4'h0, 1'b0, 1);
    t(OP_LOAD, MODE_INDEX, 3'h2, S, E, F, 1'b0, 4'h0, 1'b0, 1);
    t(OP_DIV, MODE_DEFER, 3'h0, S, E, 58'h0, 1'b0, 4'h0, 1'b0, 1);
    chk(result.exp, 8'h00);
    chk(result.frac, 56'h0);
    t(OP_LOAD, MODE_INDEX_DEF, 3'h1, 9'h100, E, F, 1'b0, 4'hC,
      1'b1, 0);
    t(OP_CONV, MODE_AC, 3'h0, 9'h090, E, F, 1'b0, 4'h0, 1'b0, 2);
    ctrl.conversion_trap_enable = 1'b1;
    t(OP_CONV, MODE_AC, 3'h0, 9'h090, E, F, 1'b0, 4'h6, 1'b1, 2);
    ctrl.long_integer_select = 1'b1;
    t(OP_CONV, MODE_AC, 3'h0, 9'h090, E, F, 1'b0, 4'h0, 1'b0, 2);
    t(OP_CONV, MODE_AC, 3'h0, 9'h0A0, E, F, 1'b0, 4'h6, 1'b1, 2);
    t(OP_ADD, MODE_AC, 3'h0, S, 10'h101, F, 1'b0, 4'h0, 1'b0, 1);
    ctrl.overflow_trap_enable = 1'b1;
    t(OP_ADD, MODE_AC, 3'h0, S, 10'h101, F, 1'b0, 4'h8, 1'b1, 1);
    chk(result.exp, 8'h01);
    chk(result.frac, 56'h80000000000000);
    t(OP_ADD, MODE_AC, 3'h0, S, 10'h3FF, F, 1'b0, 4'h0, 1'b0, 1);
    chk(result.exp, 8'h00);
    chk(result.frac, 56'h0);
    ctrl.underflow_trap_enable = 1'b1;
    t(OP_ADD, MODE_AC, 3'h0, S, 10'h3FF, F, 1'b0, 4'hA, 1'b1, 1);
    chk(result.exp, 8'hFF);
    ctrl.global_trap_inhibit = 1'b1;
    t(OP_ILLEGAL, MODE_AC, 3'h0, S, E, F, 1'b0, 4'h2, 1'b0, 0);
    ctrl.global_trap_inhibit = 1'b0;
    t(OP_OTHER, MODE_AC, 3'h0, S, E, F, 1'b1, 4'h0, 1'b0, 2);
    ctrl.maint_trap_enable = 1'b1;
    t(OP_OTHER, MODE_AC, 3'h0, S, E, F, 1'b1, 4'hE, 1'b1, 2);
    t(OP_ADD, MODE_AC, 3'h0, S, E, F, 1'b0, 4'h0, 1'b0, 1);
    chk(sticky_error_flag, 1'b1);
    fpx_host_model_inst.status(1'b0);
    chk(status_read_valid, 1'b1);
    chk(exception_code, xc);
    fpx_host_model_inst.status(1'b1);
    chk(sticky_error_flag, 1'b0);
    t(OP_ADD, MODE_AC, 3'h0, S, E, 58'h200000200000000, 1'b0, 4'h0,
      1'b0, 1);
    chk(result.frac, 56'h80000100000000);
    chk(sticky_error_flag, 1'b0);
    ctrl.precision_select = 1'b1;
    @(negedge sys_clk);
    chk(addr_step, 4'h8);
    t(OP_ADD, MODE_AC, 3'h0, S, E, 58'h200000000000006, 1'b0, 4'h0,
      1'b0, 1);
    chk(result.frac, 56'h80000000000002);
    mem_word_idx = 2'h0;
    @(negedge sys_clk);
    chk(mem_word, 16'h4000);
    mem_word_idx = 2'h3;
    @(negedge sys_clk);
    chk(mem_word, 16'h0002);
    ctrl.chop_select = 1'b1;
    t(OP_ADD, MODE_AC, 3'h0, S, E, 58'h200000000000006, 1'b0, 4'h0,
      1'b0, 1);
    chk(result.frac, 56'h80000000000001);
    resetn = 1'b0;
    @(negedge sys_clk);
    resetn = 1'b1;
    chk(exception_code, 4'h0);
    chk(exception_address, 16'h0000);
    chk(trap_vector, 9'h0A4);
    xc = 4'h0;
    xa = 16'h0000;
    t(OP_ILLEGAL, MODE_AC, 3'h0, S, E, F, 1'b0, 4'h2, 1'b1, 0);
    report_and_stop;
  end
endmodule // tb_top
